// ### design/twcs_deglitch.sv
/*
  Glitch filter: output follows the input only after it has held a new
  level for N consecutive clocks. Input must already be synchronised.
*/
`timescale 1ns/100ps
module twcs_deglitch #(
  parameter int N = 3
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic [3:0] cnt;
  wire        differs = d_i != q_o;
  wire        settled = cnt == 4'(N - 1);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= 1'b1;
      cnt <= 4'h0;
    end else if (!differs) begin
      cnt <= 4'h0;
    end else if (settled) begin
      q_o <= d_i; // RULE_08
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// ### design/twcs_pkg.sv
/*
  Constants shared by the two-wire configuration slave.
  Assumes a single 25 MHz crystal reference clock for all logic.
*/
// Contract
// (RULE_01) Answer to 7-bit address 100110 plus strap bit as least bit.
// (RULE_02) Host addresses 0x98 with strap low, 0x9A with strap high.
// (RULE_03) Watch both lines; start is SDA falling with SCL high; idle until start.
// (RULE_04) Host sends 7-bit address then direction bit, one for read.
// (RULE_05) Acknowledge own address in the slot after the address byte.
// (RULE_06) Bytes follow acknowledged address; stop or repeated start ends transfer.
// (RULE_07) Driver keeps SDA stable while SCL is high.
// (RULE_08) SCL deglitched and delayed three crystal clocks; write data taken on its rise.
// (RULE_09) Read data changes only after delayed SCL falls.
// (RULE_10) First written byte loads the pointer; next byte goes to that register.
// (RULE_11) Pointer advances after every written data byte.
// (RULE_12) Pointer advances after every byte read.
// (RULE_13) Host sets the register address before reading or writing data.
// (RULE_14) Power-on reset restores defaults over 512k crystal clocks.
// (RULE_15) External reset pin gives the same full reset; may be tied high. Code reruns the sequence and register defaults but keeps ptr.
// (RULE_16) Writing 0x0F to register 0x2C enters standby.
// (RULE_17) Serial port keeps working in standby.
// (RULE_18) Sync status registers 0x01 and 0x02 keep updating in standby.
// (RULE_19) SDA released except for acknowledge or low read bit; no foreign acks.
package twcs_pkg;
  // ==========================================================================
  // Bus address
  localparam logic [5:0] ADDR_HI       = 6'h26;
  // ==========================================================================
  // Register map
  localparam logic [7:0] REG_STAT_SEL  = 8'h01;
  localparam logic [7:0] REG_STAT_ACT  = 8'h02;
  localparam logic [7:0] REG_STANDBY   = 8'h2C;
  localparam logic [7:0] STANDBY_VAL   = 8'h0F;
  localparam logic [7:0] REG_DEFAULT   = 8'h00;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEGLITCH_NS   = 120;
  localparam int DEGLITCH_CYC  = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CLKS      = 512 * 1024;
  // ==========================================================================
  // Protocol states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_PTR   = 3'b010,
    ST_WDATA = 3'b011,
    ST_ACK   = 3'b100,
    ST_RDATA = 3'b101,
    ST_RACK  = 3'b110
  } twcs_state_t;
endpackage

// ### design/twcs_slave.sv
/*
  Two-wire configuration slave with register file, power-on reset
  sequencer and standby control. Assumes SCL and SDA arrive from pins,
  an open-drain SDA resolved outside, and status bytes on this clock.
*/
`timescale 1ns/100ps
module twcs_slave import twcs_pkg::*; #(
  parameter int POR_CYCLES = POR_CLKS,
  parameter int NREG       = 256
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       ext_rst_n_i,
  input  wire logic       addr_sel_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  input  wire logic [7:0] stat_sel_i,
  input  wire logic [7:0] stat_act_i,
  output logic            standby_o,
  output logic            reset_busy_o
);
  // ==========================================================================
  // Pin synchronisers
  logic [1:0] scl_sy, sda_sy, ext_sy, sel_sy;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      ext_sy <= 2'h0;
      sel_sy <= 2'h0;
    end else begin
      scl_sy <= {scl_sy[0], scl_i};
      sda_sy <= {sda_sy[0], sda_i};
      ext_sy <= {ext_sy[0], ext_rst_n_i};
      sel_sy <= {sel_sy[0], addr_sel_i};
    end
  end

  // ==========================================================================
  // Deglitch; SDA gets the same delay so start/stop stay aligned to SCL
  logic scl_f, sda_f, scl_q, sda_q;
  twcs_deglitch #(.N(DEGLITCH_CYC)) u_scl_dg (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .d_i       (scl_sy[1]),
    .q_o       (scl_f)
  );
  twcs_deglitch #(.N(DEGLITCH_CYC)) u_sda_dg (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .d_i       (sda_sy[1]),
    .q_o       (sda_f)
  );
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  wire scl_rise = scl_f & ~scl_q; // RULE_08
  wire scl_fall = ~scl_f & scl_q; // RULE_09
  wire start_c  = scl_f & scl_q & sda_q & ~sda_f; // RULE_03
  wire stop_c   = scl_f & scl_q & ~sda_q & sda_f; // RULE_06

  // ==========================================================================
  // Reset sequencer; pin reset restarts the full count
  logic [19:0] por_cnt;
  logic        por_busy;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_cnt  <= 20'(POR_CYCLES - 1);
      por_busy <= 1'b1;
    end else if (!ext_sy[1]) begin
      por_cnt  <= 20'(POR_CYCLES - 1); // RULE_15
      por_busy <= 1'b1;
    end else if (por_cnt != 20'h0) begin
      por_cnt  <= por_cnt - 20'h1; // RULE_14
    end else begin
      por_busy <= 1'b0;
    end
  end

  // ==========================================================================
  // Protocol engine
  twcs_state_t state, ack_next;
  logic [2:0]  bit_cnt;
  logic [7:0]  rx_sh, tx_sh, ptr;
  logic        byte_rdy, sda_drv;
  logic [7:0]  regs [NREG];

  wire [6:0] own_addr   = {ADDR_HI, sel_sy[1]}; // RULE_01
  wire       addr_match = rx_sh[7:1] == own_addr;
  wire       receiving  = state == ST_ADDR || state == ST_PTR || state == ST_WDATA;
  wire       byte_end   = scl_fall & byte_rdy;
  wire       wr_en      = byte_end & (state == ST_WDATA) & ~por_busy;
  wire       wr_ok      = ptr != REG_STAT_SEL && ptr != REG_STAT_ACT;
  // Status bytes are live so detection results show even in standby
  wire [7:0] rd_byte    = (ptr == REG_STAT_SEL) ? stat_sel_i :       // RULE_18
                          (ptr == REG_STAT_ACT) ? stat_act_i : regs[ptr];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state    <= ST_IDLE;
      ack_next <= ST_IDLE;
      bit_cnt  <= 3'h0;
      rx_sh    <= 8'h00;
      tx_sh    <= 8'h00;
      ptr      <= 8'h00;
      byte_rdy <= 1'b0;
      sda_drv  <= 1'b0;
    end else if (por_busy || stop_c) begin
      state    <= ST_IDLE; // RULE_06
      sda_drv  <= 1'b0;
      byte_rdy <= 1'b0;
    end else if (start_c) begin
      state    <= ST_ADDR; // RULE_03
      bit_cnt  <= 3'h0;
      sda_drv  <= 1'b0;
      byte_rdy <= 1'b0;
    end else if (scl_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      if (receiving) begin
        rx_sh    <= {rx_sh[6:0], sda_f}; // RULE_08
        byte_rdy <= bit_cnt == 3'h7;
      end
      if (state == ST_RACK && sda_f) begin
        state <= ST_IDLE; // Master ended the read with a nack
      end
    end else if (scl_fall) begin
      byte_rdy <= 1'b0;
      case (state)
        ST_ADDR: if (byte_rdy) begin
          if (addr_match) begin
            sda_drv  <= 1'b1; // RULE_05
            state    <= ST_ACK;
            ack_next <= rx_sh[0] ? ST_RDATA : ST_PTR;
          end else begin
            state    <= ST_IDLE; // RULE_19
          end
        end
        ST_PTR: if (byte_rdy) begin
          ptr      <= rx_sh; // RULE_10
          sda_drv  <= 1'b1;
          state    <= ST_ACK;
          ack_next <= ST_WDATA;
        end
        ST_WDATA: if (byte_rdy) begin
          ptr      <= ptr + 8'h1; // RULE_11
          sda_drv  <= 1'b1;
          state    <= ST_ACK;
          ack_next <= ST_WDATA;
        end
        ST_ACK, ST_RACK: begin
          bit_cnt <= 3'h0;
          if (ack_next == ST_RDATA) begin
            tx_sh   <= rd_byte;
            sda_drv <= ~rd_byte[7]; // RULE_19
            ptr     <= ptr + 8'h1;  // RULE_12
            state   <= ST_RDATA;
          end else begin
            sda_drv <= 1'b0;
            state   <= ack_next;
          end
        end
        ST_RDATA: if (bit_cnt == 3'h0) begin
          sda_drv <= 1'b0;
          state   <= ST_RACK;
        end else begin
          tx_sh   <= {tx_sh[6:0], 1'b0};
          sda_drv <= ~tx_sh[6]; // RULE_09
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Register file and standby
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NREG; i++) regs[i] <= REG_DEFAULT;
    end else if (por_busy) begin
      for (int i = 0; i < NREG; i++) regs[i] <= REG_DEFAULT; // RULE_14
    end else if (wr_en && wr_ok) begin
      regs[ptr] <= rx_sh; // RULE_17
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      standby_o <= 1'b0;
    end else begin
      standby_o <= ~por_busy && regs[REG_STANDBY] == STANDBY_VAL; // RULE_16
    end
  end

  // Open drain: only ever pulls low
  assign sda_o        = 1'b0;
  assign sda_oe_n_o   = ~sda_drv; // RULE_19
  assign reset_busy_o = por_busy;

  // ==========================================================================
  // Checks
  chk_idle_release: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_03
    state == ST_IDLE |-> sda_oe_n_o)
    else $error("SDA driven while idle");
  chk_drive_on_fall: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_07
    $changed(sda_drv) |-> $past(scl_fall | start_c | stop_c | por_busy))
    else $error("SDA drive changed outside SCL low");
  chk_scl_delay: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_08
    $rose(scl_f) |-> $past(scl_sy[1], 1) && $past(scl_sy[1], 2) && $past(scl_sy[1], 3))
    else $error("SCL passed without three stable clocks");
  chk_addr_ack: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_05
    (state == ST_ADDR && byte_end && addr_match && !start_c && !stop_c && !por_busy)
      |=> !sda_oe_n_o && state == ST_ACK)
    else $error("Own address not acknowledged");
  chk_no_foreign: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_19
    (state == ST_ADDR && byte_end && !addr_match && !start_c && !stop_c)
      |=> state == ST_IDLE && sda_oe_n_o)
    else $error("Foreign address acknowledged");
  chk_ptr_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_10
    (state == ST_PTR && byte_end && !start_c && !stop_c && !por_busy)
      |=> ptr == $past(rx_sh) ##1 (state == ST_ACK || state == ST_WDATA))
    else $error("Pointer not loaded from first byte");
  chk_ptr_inc: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_11
    wr_en && !start_c && !stop_c |=> ptr == $past(ptr) + 8'h1)
    else $error("Pointer not advanced after write");
  chk_standby_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_16
    (wr_en && ptr == REG_STANDBY && rx_sh == STANDBY_VAL && !stop_c && !start_c)
      |=> ##1 standby_o)
    else $error("Standby not entered");
  chk_ext_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE_15
    !ext_sy[1] |=> por_busy [*2])
    else $error("Pin reset did not restart sequence");
  cov_write: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) wr_en && wr_ok);
  cov_read: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state == ST_RACK ##1 state == ST_RDATA);
  cov_standby: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $rose(standby_o));
  cov_nack: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state == ST_RACK ##1 state == ST_IDLE);
endmodule

// ### tb/twcs_host.sv
/*
  Host model: two-wire bus master driving SCL and its half of SDA.
  Assumes the bench resolves SDA from both open-drain sides with a pull-up.
*/
`timescale 1ns/100ps
module twcs_host #(
  parameter int HALF = 12
) (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ==========================================================================
  // Idle bus
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // ==========================================================================
  // Bus phases
  // Twelve clocks a half bit keeps every level well past the slave filter
  task automatic half();
    repeat (HALF) @(posedge clk_sys_i);
  endtask
  // SDA moves three clocks into the low phase, clear of the delayed clock
  task automatic start();
    repeat (3) @(posedge clk_sys_i);
    sda_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_o <= 1'b0;
    half();
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    repeat (3) @(posedge clk_sys_i);
    sda_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_o <= 1'b1;
    half();
  endtask
  task automatic bit_io(input logic b, output logic r);
    repeat (3) @(posedge clk_sys_i);
    sda_o <= b;
    half();
    scl_o <= 1'b1;
    half();
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Host nack on the last byte ends the read
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~more, r);
  endtask
endmodule

// ### tb/twcs_slave_tb.sv
/*
  Self-checking bench for the two-wire configuration slave.
  Assumes the host model as bus master and a pull-up on SDA.
*/
`timescale 1ns/100ps
module twcs_slave_tb;
  // ==========================================================================
  // Wiring
  logic       clk_sys_i;
  logic       rst_n_i;
  logic       ext_rst_n;
  logic       addr_sel;
  logic [7:0] stat_sel;
  logic [7:0] stat_act;
  logic       scl;
  logic       host_sda;
  logic       sda_o;
  logic       sda_oe_n;
  logic       standby;
  logic       busy;
  logic       scl_q;
  logic       oe_q;
  logic       ack;
  int         fails;
  int         n_checks;
  wire        sda_line = host_sda & (sda_oe_n | sda_o);

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  twcs_slave #(.POR_CYCLES(64)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ext_rst_n_i(ext_rst_n),
    .addr_sel_i(addr_sel), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .stat_sel_i(stat_sel), .stat_act_i(stat_act),
    .standby_o(standby), .reset_busy_o(busy));

  twcs_host host_u (.clk_sys_i(clk_sys_i), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda));

  // ==========================================================================
  // Checking
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Slave may only move SDA while the host holds SCL low
  // Gated by reset: drive state is unknown before the first reset edge
  always @(posedge clk_sys_i) begin
    scl_q <= scl;
    oe_q  <= sda_oe_n;
    if (rst_n_i === 1'b1 && scl && scl_q && sda_oe_n !== oe_q) begin
      check({7'h00, sda_oe_n}, {7'h00, oe_q});
    end
  end

  task automatic wait_ready(input int lim);
    for (int i = 0; i < lim && busy !== 1'b0; i++) @(posedge clk_sys_i);
    #1;
    check({7'h00, busy}, 8'h00);
    if (busy !== 1'b0) complete_run();
  endtask

  // ==========================================================================
  // Transfers
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$]);
    host_u.start();
    host_u.send(8'h98, ack);
    check({7'h00, ack}, 8'h01);
    host_u.send(ptr, ack);
    check({7'h00, ack}, 8'h01);
    foreach (d[i]) begin
      host_u.send(d[i], ack);
      check({7'h00, ack}, 8'h01);
    end
    host_u.stop();
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] e [$]);
    logic [7:0] v;
    host_u.start();
    host_u.send(8'h98, ack);
    host_u.send(ptr, ack);
    host_u.start();
    host_u.send(8'h99, ack);
    check({7'h00, ack}, 8'h01);
    foreach (e[i]) begin
      host_u.recv(i < e.size() - 1, v);
      check(v, e[i]);
    end
    host_u.stop();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    repeat (60) @(posedge clk_sys_i);
    #1;
    check({6'h00, busy, sda_oe_n}, 8'h03);
    check({7'h00, standby}, 8'h00);
    wait_ready(40);
  endtask

  task automatic t_no_start();
    host_u.send(8'h98, ack);
    check({7'h00, ack}, 8'h00);
    host_u.stop();
  endtask

  task automatic t_addr_match();
    host_u.start();
    host_u.send(8'h9A, ack);
    check({7'h00, ack}, 8'h00);
    host_u.stop();
    addr_sel <= 1'b1;
    host_u.start();
    host_u.send(8'h9A, ack);
    check({7'h00, ack}, 8'h01);
    host_u.stop();
    addr_sel <= 1'b0;
  endtask

  // Burst crosses the pointer wrap from 0xFF to 0x00
  task automatic t_burst();
    wr(8'hFE, {8'hA5, 8'h5A, 8'hC3});
    rd(8'hFE, {8'hA5, 8'h5A, 8'hC3});
  endtask

  task automatic t_standby();
    wr(8'h2C, {8'h0F});
    check({7'h00, standby}, 8'h01);
    rd(8'h01, {8'h3C, 8'hC3});
    stat_sel <= 8'h81;
    // Status bytes are acked but never stored
    wr(8'h01, {8'h55, 8'h77});
    rd(8'h01, {8'h81, 8'hC3});
    wr(8'h10, {8'h66});
    rd(8'h10, {8'h66});
  endtask

  task automatic t_ext_reset();
    ext_rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    ext_rst_n <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    check({7'h00, busy}, 8'h01);
    wait_ready(100);
    check({7'h00, standby}, 8'h00);
    rd(8'hFE, {8'h00});
  endtask

  initial begin
    rst_n_i   = 1'b0;
    ext_rst_n = 1'b1;
    addr_sel  = 1'b0;
    stat_sel  = 8'h3C;
    stat_act  = 8'hC3;
    fails     = 0;
    n_checks  = 0;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_no_start();
    t_addr_match();
    t_burst();
    t_standby();
    t_ext_reset();
    complete_run();
  end
endmodule
